/* File: agu_pkg.sv */
// Constants and types shared by the long indirect address field decoder
`default_nettype none

package agu_pkg;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int PTR_W   = 32;
  localparam int FIELD_W = 16;
  localparam int NUM_PTR = 16;
  localparam int SEL_W   = 4;

  typedef logic [PTR_W-1:0]              ptr_t;
  typedef logic [NUM_PTR-1:0][PTR_W-1:0] ptr_bank_t;
  typedef logic [SEL_W-1:0]              sel_t;

  // ==========================================================================
  // Placement of the field inside a non-move instruction
  // ==========================================================================
  localparam int INSTR_FIELD_MSB = 31;
  localparam int INSTR_FIELD_LSB = 16;

  // ==========================================================================
  // Bit positions inside the 16-bit field
  // ==========================================================================
  localparam int MODE_MSB  = 15;
  localparam int TOP2_LSB  = 14;
  localparam int TOP3_LSB  = 13;
  localparam int TOP4_LSB  = 12;
  localparam int BASE_MSB  = 3;
  localparam int BASE_LSB  = 0;
  localparam int IDX_MSB   = 5;
  localparam int IDX_LSB   = 4;
  localparam int WB_MSB    = 9;
  localparam int WB_LSB    = 6;
  localparam int SHIFT_MSB = 11;
  localparam int SHIFT_LSB = 10;
  localparam int U10_MSB   = 13;
  localparam int U10_LSB   = 4;
  localparam int U7_MSB    = 12;
  localparam int U7_LSB    = 6;
  localparam int U8_MSB    = 11;
  localparam int U8_LSB    = 4;
  localparam int N13_MSB   = 12;
  localparam int N13_LSB   = 0;

  // ==========================================================================
  // Mode codes in the top bits of the field
  // ==========================================================================
  localparam logic [1:0] CODE_OFFSET        = 2'h0;
  localparam logic [1:0] CODE_OFFSET_SCALED = 2'h1;
  localparam logic [2:0] CODE_OFFSET_INDEX  = 3'h4;
  localparam logic [2:0] CODE_STACK_REL     = 3'h5;
  localparam logic [3:0] CODE_POST_INC      = 4'hC;
  localparam logic [3:0] CODE_POST_DEC      = 4'hD;
  localparam logic [3:0] CODE_PRE_DEC       = 4'hE;
  localparam logic [3:0] CODE_INDEX_SCALED  = 4'hF;

  typedef enum {
    MODE_OFFSET,
    MODE_OFFSET_SCALED,
    MODE_OFFSET_INDEX,
    MODE_STACK_REL,
    MODE_POST_INC,
    MODE_POST_DEC,
    MODE_PRE_DEC,
    MODE_INDEX_SCALED
  } addr_mode_t;

  // ==========================================================================
  // Fixed values
  // ==========================================================================
  localparam sel_t       SP_SEL       = 4'hF;
  localparam sel_t       NO_WB_SEL    = 4'hF;
  localparam logic [1:0] IDX_PAD      = 2'h0;
  localparam logic [1:0] OFFSET_SHIFT = 2'h2;
  localparam ptr_t       PTR_ONE      = 32'h0000_0001;
  localparam ptr_t       PTR_RESET    = 32'h0000_0000;

endpackage

`default_nettype wire

/* File: addr_field_decode.sv */
// One long indirect address field: effective address and pointer write-back
`timescale 1ns/10ps
`default_nettype none

module addr_field_decode (
  input  wire logic [agu_pkg::FIELD_W-1:0] field,
  input  wire agu_pkg::ptr_bank_t          ptrs,
  output var  agu_pkg::ptr_t               addr,
  output var  logic                        wb_en,
  output var  agu_pkg::sel_t               wb_sel,
  output var  agu_pkg::ptr_t               wb_val,
  output var  logic                        illegal
);

  agu_pkg::addr_mode_t mode;
  agu_pkg::sel_t       base_sel;
  agu_pkg::ptr_t       base;
  agu_pkg::ptr_t       index;
  agu_pkg::ptr_t       scaled_index;
  agu_pkg::ptr_t       step_down;

  // ==========================================================================
  // Mode decode
  // ==========================================================================
  always_comb
  begin
    if (field[agu_pkg::MODE_MSB:agu_pkg::TOP2_LSB] == agu_pkg::CODE_OFFSET)
      mode = agu_pkg::MODE_OFFSET;
    else if (field[agu_pkg::MODE_MSB:agu_pkg::TOP2_LSB] == agu_pkg::CODE_OFFSET_SCALED)
      mode = agu_pkg::MODE_OFFSET_SCALED;
    else if (field[agu_pkg::MODE_MSB:agu_pkg::TOP3_LSB] == agu_pkg::CODE_OFFSET_INDEX)
      mode = agu_pkg::MODE_OFFSET_INDEX;
    else if (field[agu_pkg::MODE_MSB:agu_pkg::TOP3_LSB] == agu_pkg::CODE_STACK_REL)
      mode = agu_pkg::MODE_STACK_REL;
    else if (field[agu_pkg::MODE_MSB:agu_pkg::TOP4_LSB] == agu_pkg::CODE_POST_INC)
      mode = agu_pkg::MODE_POST_INC;
    else if (field[agu_pkg::MODE_MSB:agu_pkg::TOP4_LSB] == agu_pkg::CODE_POST_DEC)
      mode = agu_pkg::MODE_POST_DEC;
    else if (field[agu_pkg::MODE_MSB:agu_pkg::TOP4_LSB] == agu_pkg::CODE_PRE_DEC)
      mode = agu_pkg::MODE_PRE_DEC;
    else
      mode = agu_pkg::MODE_INDEX_SCALED;
  end

  // ==========================================================================
  // Address and write-back, all arithmetic wraps at pointer width
  // ==========================================================================
  always_comb
  begin
    base_sel     = field[agu_pkg::BASE_MSB:agu_pkg::BASE_LSB];
    base         = ptrs[base_sel];
    // Index select is only two bits wide, so only the low four pointers qualify
    index        = ptrs[{agu_pkg::IDX_PAD, field[agu_pkg::IDX_MSB:agu_pkg::IDX_LSB]}];
    scaled_index = index << field[agu_pkg::SHIFT_MSB:agu_pkg::SHIFT_LSB];
    // Encoded step n stands for n+1, giving 1 to 256
    step_down    = agu_pkg::ptr_t'(field[agu_pkg::U8_MSB:agu_pkg::U8_LSB]) + agu_pkg::PTR_ONE;
    addr         = base;
    wb_en        = 1'b0;
    wb_sel       = base_sel;
    wb_val       = base;
    illegal      = 1'b0;
    case (mode)
      agu_pkg::MODE_OFFSET:
      begin
        addr = base + agu_pkg::ptr_t'(field[agu_pkg::U10_MSB:agu_pkg::U10_LSB]);
      end
      agu_pkg::MODE_OFFSET_SCALED:
      begin
        addr = base + (agu_pkg::ptr_t'(field[agu_pkg::U10_MSB:agu_pkg::U10_LSB]) << agu_pkg::OFFSET_SHIFT);
      end
      agu_pkg::MODE_OFFSET_INDEX:
      begin
        addr   = base + agu_pkg::ptr_t'(field[agu_pkg::U7_MSB:agu_pkg::U7_LSB]);
        wb_en  = 1'b1;
        wb_val = base + index;
      end
      agu_pkg::MODE_STACK_REL:
      begin
        wb_sel = agu_pkg::SP_SEL;
        addr   = ptrs[agu_pkg::SP_SEL] - (agu_pkg::ptr_t'(field[agu_pkg::N13_MSB:agu_pkg::N13_LSB])
                 + agu_pkg::PTR_ONE);
      end
      agu_pkg::MODE_POST_INC:
      begin
        wb_en  = 1'b1;
        wb_val = base + agu_pkg::ptr_t'(field[agu_pkg::U8_MSB:agu_pkg::U8_LSB]);
      end
      agu_pkg::MODE_POST_DEC:
      begin
        wb_en  = 1'b1;
        wb_val = base - step_down;
      end
      agu_pkg::MODE_PRE_DEC:
      begin
        wb_en  = 1'b1;
        wb_val = base - step_down;
        addr   = wb_val;
      end
      agu_pkg::MODE_INDEX_SCALED:
      begin
        addr   = base + scaled_index;
        wb_sel = field[agu_pkg::WB_MSB:agu_pkg::WB_LSB];
        wb_en  = (wb_sel != agu_pkg::NO_WB_SEL);
        wb_val = base + scaled_index;
      end
      default:
      begin
        illegal = 1'b1;
      end
    endcase
    // The stack pointer cannot carry an index step, a post-decrement or a scaled index
    if ((mode != agu_pkg::MODE_STACK_REL) && (base_sel == agu_pkg::SP_SEL)
        && ((mode == agu_pkg::MODE_OFFSET_INDEX) || (mode == agu_pkg::MODE_POST_DEC)
        || (mode == agu_pkg::MODE_INDEX_SCALED)))
    begin
      illegal = 1'b1;
      wb_en   = 1'b0;
    end
  end

endmodule // addr_field_decode

`default_nettype wire

/* File: pointer_file.sv */
// Pointer register bank with two write-back ports and one load port
`timescale 1ns/10ps
`default_nettype none

module pointer_file (
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire logic               ce,
  input  wire logic               wr_a_en,
  input  wire agu_pkg::sel_t      wr_a_sel,
  input  wire agu_pkg::ptr_t      wr_a_val,
  input  wire logic               wr_b_en,
  input  wire agu_pkg::sel_t      wr_b_sel,
  input  wire agu_pkg::ptr_t      wr_b_val,
  input  wire logic               load_en,
  input  wire agu_pkg::sel_t      load_sel,
  input  wire agu_pkg::ptr_t      load_val,
  output var  agu_pkg::ptr_bank_t ptrs
);

  typedef struct packed {
    agu_pkg::ptr_bank_t regs;
  } file_state_t;

  file_state_t state;
  file_state_t next_state;

  // ==========================================================================
  // Write priority: load lowest, then port a, then port b
  // ==========================================================================
  always_comb
  begin
    next_state = state;
    if (load_en)
      next_state.regs[load_sel] = load_val;
    if (wr_a_en)
      next_state.regs[wr_a_sel] = wr_a_val;
    if (wr_b_en)
      next_state.regs[wr_b_sel] = wr_b_val;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      state <= '{regs: {agu_pkg::NUM_PTR{agu_pkg::PTR_RESET}}};
    else if (ce)
      state <= next_state;
  end

  assign ptrs = state.regs;

endmodule // pointer_file

`default_nettype wire

/* File: long_address_field_agu.sv */
// Top of the long indirect address field unit: field select, decode, registered outputs
`timescale 1ns/10ps
`default_nettype none

// Contract
// - The address field is 16 bits and encodes all pointer and stack modes.
// - Outside data moves the field is taken from instruction bits 31 to 16.
// - Data moves carry separate source and destination fields; others carry one.
// - Unscaled offset: base plus unsigned 10-bit byte offset, no pointer update.
// - Scaled offset: 10-bit offset shifted left two, added to base.
// - Address is base plus 7-bit offset, then base advances by index pointer.
// - Stack relative: stack pointer minus 1 to 8192, stack pointer unchanged.
// - Post-increment: address is base, then base grows by 0 to 255.
// - Post-decrement: address is base, then base shrinks by 1 to 256.
// - Pre-decrement: base shrinks by 1 to 256 first, then used as address.
// - Scaled index: base plus index pointer shifted by 0 to 3, no update when the write-back field is 15.
// - Scaled index with write-back stores the computed address in the destination pointer.
// - Modes invalid for the stack pointer are refused when it is the base.
// - Stack post-increment 0 to 255 and pre-decrement 1 to 256 are supported.
module long_address_field_agu (
  input  wire logic                        CLK,
  input  wire logic                        RESET,
  input  wire logic                        CE,
  input  wire logic                        INSTR_VALID,
  input  wire logic [31:0]                 INSTRUCTION,
  input  wire logic                        IS_DATA_MOVE,
  input  wire logic [agu_pkg::FIELD_W-1:0] MOVE_SOURCE_FIELD,
  input  wire logic [agu_pkg::FIELD_W-1:0] MOVE_DEST_FIELD,
  input  wire logic                        PTR_LOAD_EN,
  input  wire agu_pkg::sel_t               PTR_LOAD_SEL,
  input  wire agu_pkg::ptr_t               PTR_LOAD_DATA,
  input  wire agu_pkg::sel_t               PTR_READ_SEL,
  output var  logic                        ADDR_VALID,
  output var  agu_pkg::ptr_t               PRIMARY_ADDR,
  output var  logic                        DEST_ADDR_VALID,
  output var  agu_pkg::ptr_t               DEST_ADDR,
  output var  logic                        ADDR_ILLEGAL,
  output var  agu_pkg::ptr_t               PTR_READ_DATA
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic          addr_valid;
    agu_pkg::ptr_t primary_addr;
    logic          dest_valid;
    agu_pkg::ptr_t dest_addr;
    logic          illegal;
    agu_pkg::ptr_t read_data;
  } agu_state_t;

  agu_state_t state;
  agu_state_t next_state;

  logic [agu_pkg::FIELD_W-1:0] field_a;
  logic [agu_pkg::FIELD_W-1:0] field_b;
  agu_pkg::ptr_bank_t          ptrs;
  agu_pkg::ptr_t               addr_a;
  agu_pkg::ptr_t               addr_b;
  logic                        wb_a_en;
  logic                        wb_b_en;
  agu_pkg::sel_t               wb_a_sel;
  agu_pkg::sel_t               wb_b_sel;
  agu_pkg::ptr_t               wb_a_val;
  agu_pkg::ptr_t               wb_b_val;
  logic                        illegal_a;
  logic                        illegal_b;
  logic                        take;
  logic                        refuse;
  logic                        commit_a;
  logic                        commit_b;

  // ==========================================================================
  // Field selection
  // ==========================================================================
  always_comb
  begin
    if (IS_DATA_MOVE)
      field_a = MOVE_SOURCE_FIELD;
    else
      field_a = INSTRUCTION[agu_pkg::INSTR_FIELD_MSB:agu_pkg::INSTR_FIELD_LSB];
    field_b = MOVE_DEST_FIELD;
  end

  // ==========================================================================
  // Decoders, one per field
  // ==========================================================================
  addr_field_decode u_decode_a (
    .field   (field_a),
    .ptrs    (ptrs),
    .addr    (addr_a),
    .wb_en   (wb_a_en),
    .wb_sel  (wb_a_sel),
    .wb_val  (wb_a_val),
    .illegal (illegal_a)
  );

  addr_field_decode u_decode_b (
    .field   (field_b),
    .ptrs    (ptrs),
    .addr    (addr_b),
    .wb_en   (wb_b_en),
    .wb_sel  (wb_b_sel),
    .wb_val  (wb_b_val),
    .illegal (illegal_b)
  );

  // ==========================================================================
  // Commit control
  // ==========================================================================
  // A refused field cancels the whole instruction so no half update is left behind
  assign take     = INSTR_VALID;
  assign refuse   = illegal_a | (IS_DATA_MOVE & illegal_b);
  assign commit_a = take & ~refuse & wb_a_en;
  assign commit_b = take & ~refuse & IS_DATA_MOVE & wb_b_en;

  // Destination write-back lands after source write-back, so it wins a clash
  pointer_file u_pointers (
    .clk      (CLK),
    .reset    (RESET),
    .ce       (CE),
    .wr_a_en  (commit_a),
    .wr_a_sel (wb_a_sel),
    .wr_a_val (wb_a_val),
    .wr_b_en  (commit_b),
    .wr_b_sel (wb_b_sel),
    .wr_b_val (wb_b_val),
    .load_en  (PTR_LOAD_EN),
    .load_sel (PTR_LOAD_SEL),
    .load_val (PTR_LOAD_DATA),
    .ptrs     (ptrs)
  );

  always_comb
  begin
    next_state            = state;
    next_state.addr_valid = take & ~refuse;
    next_state.dest_valid = take & ~refuse & IS_DATA_MOVE;
    next_state.illegal    = take & refuse;
    next_state.read_data  = ptrs[PTR_READ_SEL];
    if (take)
    begin
      next_state.primary_addr = addr_a;
      next_state.dest_addr    = addr_b;
    end
  end

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
      state <= '{addr_valid: 1'b0, primary_addr: agu_pkg::PTR_RESET, dest_valid: 1'b0,
                 dest_addr: agu_pkg::PTR_RESET, illegal: 1'b0, read_data: agu_pkg::PTR_RESET};
    else if (CE)
      state <= next_state;
  end

  assign ADDR_VALID      = state.addr_valid;
  assign PRIMARY_ADDR    = state.primary_addr;
  assign DEST_ADDR_VALID = state.dest_valid;
  assign DEST_ADDR       = state.dest_addr;
  assign ADDR_ILLEGAL    = state.illegal;
  assign PTR_READ_DATA   = state.read_data;

  // ==========================================================================
  // Checks
  // ==========================================================================
  // Helpers read only by the checks below
  logic          chk_take;
  agu_pkg::sel_t chk_base_sel;
  agu_pkg::ptr_t chk_base;
  agu_pkg::ptr_t chk_index;
  agu_pkg::ptr_t chk_sp;
  agu_pkg::ptr_t chk_u10;
  agu_pkg::ptr_t chk_u7;
  agu_pkg::ptr_t chk_u8;
  agu_pkg::ptr_t chk_n13;
  logic [1:0]    chk_shift;
  agu_pkg::sel_t chk_wb_sel;
  logic [3:0]    chk_top4;

  assign chk_take     = CE & INSTR_VALID & ~IS_DATA_MOVE;
  assign chk_base_sel = INSTRUCTION[19:16];
  assign chk_base     = ptrs[chk_base_sel];
  assign chk_index    = ptrs[{2'h0, INSTRUCTION[21:20]}];
  assign chk_sp       = ptrs[4'hF];
  assign chk_u10      = {22'h00_0000, INSTRUCTION[29:20]};
  assign chk_u7       = {25'h000_0000, INSTRUCTION[28:22]};
  assign chk_u8       = {24'h00_0000, INSTRUCTION[27:20]};
  assign chk_n13      = {19'h0_0000, INSTRUCTION[28:16]};
  assign chk_shift    = INSTRUCTION[27:26];
  assign chk_wb_sel   = INSTRUCTION[25:22];
  assign chk_top4     = INSTRUCTION[31:28];

  default clocking chk_cb @(posedge CLK);
  endclocking
  default disable iff (RESET);

  unscaled_off_a: assert property (chk_take && chk_top4[3:2] == 2'h0 |=>
    ADDR_VALID && PRIMARY_ADDR == $past(chk_base) + $past(chk_u10)) else $error("unscaled offset address wrong");

  scaled_off_a: assert property (chk_take && chk_top4[3:2] == 2'h1 |=>
    PRIMARY_ADDR == $past(chk_base) + ($past(chk_u10) << 2)) else $error("scaled offset address wrong");

  offset_index_a: assert property (chk_take && chk_top4[3:1] == 3'h4 && chk_base_sel != 4'hF |=>
    PRIMARY_ADDR == $past(chk_base) + $past(chk_u7)
    && ptrs[$past(chk_base_sel)] == $past(chk_base) + $past(chk_index)) else $error("offset then index wrong");

  stack_rel_a: assert property (chk_take && chk_top4[3:1] == 3'h5 |=>
    PRIMARY_ADDR == $past(chk_sp) - $past(chk_n13) - 32'h0000_0001
    && chk_sp == $past(chk_sp)) else $error("stack relative address wrong");

  post_inc_a: assert property (chk_take && chk_top4 == 4'hC |=>
    PRIMARY_ADDR == $past(chk_base)
    && ptrs[$past(chk_base_sel)] == $past(chk_base) + $past(chk_u8)) else $error("post increment wrong");

  post_dec_a: assert property (chk_take && chk_top4 == 4'hD && chk_base_sel != 4'hF |=>
    PRIMARY_ADDR == $past(chk_base)
    && ptrs[$past(chk_base_sel)] == $past(chk_base) - $past(chk_u8) - 32'h0000_0001)
    else $error("post decrement wrong");

  pre_dec_a: assert property (chk_take && chk_top4 == 4'hE |=>
    PRIMARY_ADDR == $past(chk_base) - $past(chk_u8) - 32'h0000_0001
    && ptrs[$past(chk_base_sel)] == PRIMARY_ADDR) else $error("pre decrement wrong");

  index_scaled_a: assert property (chk_take && chk_top4 == 4'hF && chk_base_sel != 4'hF |=>
    PRIMARY_ADDR == $past(chk_base) + ($past(chk_index) << $past(chk_shift))) else $error("scaled index wrong");

  index_wb_a: assert property (chk_take && chk_top4 == 4'hF && chk_base_sel != 4'hF && chk_wb_sel != 4'hF |=>
    ptrs[$past(chk_wb_sel)] == PRIMARY_ADDR) else $error("scaled index write-back wrong");

  no_wb_keep_a: assert property (chk_take && chk_top4[3:2] == 2'h0 && !PTR_LOAD_EN |=>
    ptrs == $past(ptrs)) else $error("offset mode touched a pointer");

  sp_refuse_a: assert property (chk_take && chk_base_sel == 4'hF
    && (chk_top4 == 4'hD || chk_top4 == 4'hF || chk_top4[3:1] == 3'h4) && !PTR_LOAD_EN |=>
    ADDR_ILLEGAL && !ADDR_VALID && ptrs == $past(ptrs)) else $error("stack pointer misuse not refused");

  move_pair_a: assert property (CE && INSTR_VALID && IS_DATA_MOVE && !ADDR_ILLEGAL ##1 !ADDR_ILLEGAL
    |-> DEST_ADDR_VALID == ADDR_VALID) else $error("data move lacks destination address");

  freeze_a: assert property (!CE |=> $stable(ADDR_VALID) && $stable(PRIMARY_ADDR) && $stable(ptrs))
    else $error("state moved while clock enable low");

  // Stack pointer as base of the two step modes that stay legal for it
  stack_inc_a: assert property (chk_take && chk_top4 == 4'hC && chk_base_sel == 4'hF |=>
    ADDR_VALID && PRIMARY_ADDR == $past(chk_sp)
    && chk_sp == $past(chk_sp) + $past(chk_u8))
    else $error("stack post increment wrong");

  stack_dec_a: assert property (chk_take && chk_top4 == 4'hE && chk_base_sel == 4'hF |=>
    ADDR_VALID && PRIMARY_ADDR == chk_sp
    && chk_sp == $past(chk_sp) - $past(chk_u8) - 32'h0000_0001)
    else $error("stack pre decrement wrong");

  stack_keep_a: assert property (chk_take && chk_top4[3:1] == 3'h5 && !PTR_LOAD_EN |=>
    ADDR_VALID && !ADDR_ILLEGAL
    && ptrs == $past(ptrs))
    else $error("stack relative mode touched a pointer");

  index_nowb_a: assert property (chk_take && chk_top4 == 4'hF && chk_base_sel != 4'hF
    && chk_wb_sel == 4'hF && !PTR_LOAD_EN |=>
    ptrs == $past(ptrs))
    else $error("scaled index without write-back touched a pointer");

  // A step that carries past the top of the pointer range lands below the old base
  wrap_inc_a: assert property (chk_take && chk_top4 == 4'hC && chk_base > ~chk_u8 |=>
    ADDR_VALID && !ADDR_ILLEGAL
    && ptrs[$past(chk_base_sel)] < $past(chk_base))
    else $error("pointer step did not wrap");

  // Data move: both fields read the pointers as they stood before the instruction
  move_fields_a: assert property (CE && INSTR_VALID && IS_DATA_MOVE && MOVE_SOURCE_FIELD[15:14] == 2'h0
    && MOVE_DEST_FIELD[15:12] == 4'hC |=> DEST_ADDR_VALID
    && PRIMARY_ADDR == $past(ptrs[MOVE_SOURCE_FIELD[3:0]]) + {22'h00_0000, $past(MOVE_SOURCE_FIELD[13:4])}
    && DEST_ADDR == $past(ptrs[MOVE_DEST_FIELD[3:0]]))
    else $error("data move addresses wrong");

  move_refuse_a: assert property (CE && INSTR_VALID && IS_DATA_MOVE && MOVE_DEST_FIELD[15:12] == 4'hD
    && MOVE_DEST_FIELD[3:0] == 4'hF && !PTR_LOAD_EN |=>
    ADDR_ILLEGAL && !ADDR_VALID && !DEST_ADDR_VALID
    && ptrs == $past(ptrs))
    else $error("refused destination field did not cancel the move");

  refuse_only_a: assert property (ADDR_ILLEGAL |->
    !ADDR_VALID && !DEST_ADDR_VALID)
    else $error("refused instruction also marked valid");

  idle_quiet_a: assert property (CE && !INSTR_VALID |=>
    !ADDR_VALID && !DEST_ADDR_VALID && !ADDR_ILLEGAL)
    else $error("result flag without an instruction");

  // Pointer load and read-back ports
  load_port_a: assert property (CE && PTR_LOAD_EN && !INSTR_VALID |=>
    ptrs[$past(PTR_LOAD_SEL)] == $past(PTR_LOAD_DATA))
    else $error("pointer load lost");

  read_port_a: assert property (CE |=>
    PTR_READ_DATA == $past(ptrs[PTR_READ_SEL]))
    else $error("pointer read port wrong");

endmodule // long_address_field_agu

`default_nettype wire

/* File: instr_source.sv */
// Decode-stage model that presents one address field instruction per cycle
`timescale 1ns/10ps
`default_nettype none

module instr_source (
  input  wire logic        clk,
  output var  logic        valid,
  output var  logic [31:0] instr,
  output var  logic        move,
  output var  logic [15:0] src,
  output var  logic [15:0] dst
);
  initial
  begin
    valid = 1'b0;
    instr = 32'h0000_0000;
    move  = 1'b0;
    src   = 16'h0000;
    dst   = 16'h0000;
  end

  // ==========================================================================
  // Requests
  // ==========================================================================
  // Access width is not modelled, so every byte address counts as aligned
  task automatic put(input logic [15:0] f, input logic mv, input logic [15:0] d);
    valid = 1'b1;
    move  = mv;
    instr = mv ? {~f, ~d} : {f, ~f};
    src   = mv ? f : ~f;
    dst   = mv ? d : ~d;
    @(posedge clk);
    #1;
  endtask

  // Idle lines flip so a stale field can never pass for a fresh one
  task automatic idle();
    valid = 1'b0;
    instr = ~instr;
    src   = ~src;
    dst   = ~dst;
  endtask
endmodule  // instr_source

`default_nettype wire

/* File: long_address_field_agu_tb_top.sv */
// Self-checking testbench for the long indirect address field unit
`timescale 1ns/10ps
`default_nettype none

module long_address_field_agu_tb_top;
  logic          clk = 1'b0;
  logic          reset;
  logic          ce;
  logic          ld_en;
  agu_pkg::sel_t ld_sel;
  agu_pkg::sel_t rd_sel;
  agu_pkg::ptr_t ld_val;
  agu_pkg::ptr_t addr;
  agu_pkg::ptr_t daddr;
  agu_pkg::ptr_t rdata;
  logic          valid;
  logic          move;
  logic          av;
  logic          dav;
  logic          ill;
  logic [31:0]   instr;
  logic [15:0]   src;
  logic [15:0]   dst;
  int            n_errors = 0;
  int            n_compared = 0;

  always #25 clk = ~clk;

  instr_source src_m (.clk(clk), .valid(valid), .instr(instr), .move(move), .src(src), .dst(dst));
  long_address_field_agu uut (.CLK(clk), .RESET(reset), .CE(ce), .INSTR_VALID(valid), .INSTRUCTION(instr),
    .IS_DATA_MOVE(move), .MOVE_SOURCE_FIELD(src), .MOVE_DEST_FIELD(dst), .PTR_LOAD_EN(ld_en),
    .PTR_LOAD_SEL(ld_sel), .PTR_LOAD_DATA(ld_val), .PTR_READ_SEL(rd_sel), .ADDR_VALID(av),
    .PRIMARY_ADDR(addr), .DEST_ADDR_VALID(dav), .DEST_ADDR(daddr), .ADDR_ILLEGAL(ill), .PTR_READ_DATA(rdata));

  // ==========================================================================
  // Checks and bus tasks
  // ==========================================================================
  task automatic conclude();
    if (n_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic cmp(input agu_pkg::ptr_t got, input agu_pkg::ptr_t exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic cbit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic load(input agu_pkg::sel_t s, input agu_pkg::ptr_t v);
    ld_en  = 1'b1;
    ld_sel = s;
    ld_val = v;
    @(posedge clk);
    #1;
    ld_en  = 1'b0;
    ld_val = ~v;
    @(posedge clk);
    #1;
  endtask

  // Read port lags one edge, so two edges make the value certain
  task automatic peek(input agu_pkg::sel_t s, input agu_pkg::ptr_t e);
    src_m.idle();
    rd_sel = s;
    repeat (2) @(posedge clk);
    #1;
    cbit(av, 1'b0);
    cmp(rdata, e);
  endtask

  task automatic go(input logic [15:0] f, input logic [15:0] d, input logic mv, input logic ok,
                    input agu_pkg::ptr_t ea, input agu_pkg::ptr_t ed);
    src_m.put(f, mv, d);
    cbit(av, ok);
    cbit(ill, ~ok);
    cbit(dav, ok & mv);
    if (ok)
      cmp(addr, ea);
    if (ok & mv)
      cmp(daddr, ed);
  endtask

  task automatic go1(input logic [15:0] f, input agu_pkg::ptr_t ea);
    go(f, 16'h0000, 1'b0, 1'b1, ea, 32'h0000_0000);
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_offset();
    go1(16'h3FF3, 32'h1000_03FF);
    go1(16'h7FF3, 32'h1000_0FFC);
    peek(4'h3, 32'h1000_0000);
  endtask

  task automatic t_index();
    go1(16'h9FD3, 32'h1000_007F);
    peek(4'h3, 32'h1000_0040);
    go1(16'hFDD3, 32'h1000_0240);
    peek(4'h7, 32'h1000_0240);
    go1(16'hF3D3, 32'h1000_0080);
    peek(4'h3, 32'h1000_0040);
    peek(4'hF, 32'h0000_2000);
  endtask

  task automatic t_stack();
    go1(16'hBFFF, 32'h0000_0000);
    go1(16'hC10F, 32'h0000_2000);
    go1(16'hE0FF, 32'h0000_2000);
    peek(4'hF, 32'h0000_2000);
  endtask

  task automatic t_step();
    go1(16'hCFF2, 32'hFFFF_FFF0);
    go1(16'hDFF2, 32'h0000_00EF);
    go1(16'hE002, 32'hFFFF_FFEE);
    peek(4'h2, 32'hFFFF_FFEE);
  endtask

  task automatic t_refuse();
    go(16'hD00F, 16'h0000, 1'b0, 1'b0, 32'h0000_0000, 32'h0000_0000);
    go(16'h800F, 16'h0000, 1'b0, 1'b0, 32'h0000_0000, 32'h0000_0000);
    go(16'hF1CF, 16'h0000, 1'b0, 1'b0, 32'h0000_0000, 32'h0000_0000);
    peek(4'hF, 32'h0000_2000);
    peek(4'h7, 32'h1000_0240);
  endtask

  task automatic t_move();
    go(16'h0013, 16'hC082, 1'b1, 1'b1, 32'h1000_0041, 32'hFFFF_FFEE);
    go(16'hC083, 16'hD00F, 1'b1, 1'b0, 32'h0000_0000, 32'h0000_0000);
    peek(4'h2, 32'hFFFF_FFF6);
    peek(4'h3, 32'h1000_0040);
  endtask

  task automatic t_freeze();
    ce = 1'b0;
    src_m.put(16'hC10F, 1'b0, 16'h0000);
    cbit(av, 1'b0);
    src_m.idle();
    ce = 1'b1;
    peek(4'hF, 32'h0000_2000);
  endtask

  initial
  begin
    reset  = 1'b1;
    ce     = 1'b1;
    ld_en  = 1'b0;
    ld_sel = 4'h0;
    ld_val = 32'h0000_0000;
    rd_sel = 4'h0;
    repeat (8) @(posedge clk);
    #1;
    reset = 1'b0;
    peek(4'hF, 32'h0000_0000);
    load(4'h3, 32'h1000_0000);
    load(4'h1, 32'h0000_0040);
    load(4'hF, 32'h0000_2000);
    load(4'h2, 32'hFFFF_FFF0);
    t_offset();
    t_index();
    t_stack();
    t_step();
    t_refuse();
    t_move();
    t_freeze();
    conclude();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    conclude();
  end
endmodule  // long_address_field_agu_tb_top

`default_nettype wire
